// ===== design/bws_status_regs.v
// Bus communication and wake source status registers with fault tracking
//
// Contract
// - LIN fault code in bits 6:5: none, thermal, transmit timeout, bus timeout.
// - CAN timeout flag at bit 4, clearable, 1 means timeout seen.
// - System error at bit 3; while set selective wake cannot be enabled.
// - CAN fault code in bits 2:1 with the same four encodings.
// - CAN supply undervoltage flag at bit 0; transmitter off while it lasts.
// - Undervoltage comparator enabled only in normal or receive-only mode.
// - Transmit timeout ends on transmit input high, wake-capable or off.
// - Bus timeout ends when bus recessive, wake-capable or off.
// - Undervoltage ends as soon as supply is above threshold again.
// - After recovery, transmit resumes only after input held high for enable time.
// - Timeout flag sets on silent indication only while selective wake enabled.
// - Timeout flag raises interrupt in Stop or Normal when its mask is 1.
// - System error on config error or counter above 32, only while enabled.
// - Timeout flag clear ignored until next falling edge of interrupt output.
// - Bus status zero on reset; restart keeps bits 6:0.
// - Wake status zero on reset; restart keeps bits 10:7 and bit 1.
// - Wake status cleared entirely on entry to Fail-Safe mode.
// - Reserved bits of both registers read as zero.
`timescale 1ns/1ps
`default_nettype none
`include "bws_regs.vh"
module bws_status_regs
#(
   parameter TX_CNT_W = 16
)
(
   input wire core_clk,
   input wire rst,
   input wire restart,
   input wire [2:0] dev_mode,
   input wire cmd_valid,
   input wire [6:0] cmd_addr,
   input wire cmd_clear,
   input wire [15:0] cmd_clr_mask,
   output reg [15:0] rd_data,
   output reg rd_valid,
   input wire [1:0] can_mode,
   input wire can_tsd,
   input wire can_txd,
   input wire can_txd_to_det,
   input wire can_bus_recessive,
   input wire can_bus_to_det,
   input wire can_supply_below,
   output wire can_tx_enable,
   input wire [1:0] lin_mode,
   input wire lin_tsd,
   input wire lin_txd,
   input wire lin_txd_to_det,
   input wire lin_bus_recessive,
   input wire lin_bus_to_det,
   output wire lin_tx_enable,
   input wire selective_wake_enable_bit,
   input wire can_silent_indication,
   input wire swk_config_error,
   input wire [5:0] swk_err_count,
   output reg selective_wake_active,
   input wire selective_wake_timeout_irq_mask,
   input wire interrupt_out_n,
   output reg selective_wake_timeout_flag_irq_req,
   input wire lin_bus_wake,
   input wire can_bus_wake,
   input wire timer1_wake,
   input wire timer2_wake,
   input wire [3:0] wake_in
);
   // Transmit inputs come from pins and are synchronised first
   reg [1:0] txd_meta_reg;
   reg [1:0] txd_sync_reg;

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         txd_meta_reg <= 2'h3;
         txd_sync_reg <= 2'h3;
      end
      else
      begin
         txd_meta_reg <= {lin_txd, can_txd};
         txd_sync_reg <= txd_meta_reg;
      end
   end

   wire clr_bus = cmd_valid && cmd_clear && (cmd_addr == `BWS_ADDR_BUS_STAT);
   wire clr_wake = cmd_valid && cmd_clear && (cmd_addr == `BWS_ADDR_WAKE_STAT);

   // Channel 0 is CAN, channel 1 is LIN
   wire [1:0] ch_mode [0:1];
   wire [1:0] ch_tsd = {lin_tsd, can_tsd};
   wire [1:0] ch_txd_to_det = {lin_txd_to_det, can_txd_to_det};
   wire [1:0] ch_recessive = {lin_bus_recessive, can_bus_recessive};
   wire [1:0] ch_bus_to_det = {lin_bus_to_det, can_bus_to_det};
   wire [1:0] ch_tx_enable;
   wire [3:0] fail_fields;
   assign ch_mode[0] = can_mode;
   assign ch_mode[1] = lin_mode;
   assign can_tx_enable = ch_tx_enable[0];
   assign lin_tx_enable = ch_tx_enable[1];

   // Undervoltage is watched only in normal or receive-only mode
   wire uv_cmp_en = (can_mode == `BWS_XCVR_NORMAL) || (can_mode == `BWS_XCVR_RXONLY);
   wire uv_active = uv_cmp_en && can_supply_below;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1)
      begin : xcvr
         reg txd_to_reg;
         reg bus_to_reg;
         reg [1:0] fail_reg;
         reg [1:0] code;
         wire idle = (ch_mode[ch] == `BWS_XCVR_OFF) || (ch_mode[ch] == `BWS_XCVR_WAKE);
         wire fault_any = ch_tsd[ch] || txd_to_reg || bus_to_reg || ((ch == 0) && uv_active);
         wire field_clr = (ch == 0) ?
            (clr_bus && (cmd_clr_mask[`BWS_BUS_CAN_LO] || cmd_clr_mask[`BWS_BUS_CAN_LO+1])) :
            (clr_bus && (cmd_clr_mask[`BWS_BUS_LIN_LO] || cmd_clr_mask[`BWS_BUS_LIN_LO+1]));

         // Most severe active fault is reported when several coincide
         always @*
         begin
            if (ch_tsd[ch])
               code = `BWS_FAIL_TSD;
            else if (bus_to_reg || ch_bus_to_det[ch])
               code = `BWS_FAIL_BUS_TO;
            else if (txd_to_reg || ch_txd_to_det[ch])
               code = `BWS_FAIL_TXD_TO;
            else
               code = `BWS_FAIL_NONE;
         end

         always @(posedge core_clk)
         begin
            if (rst)
            begin
               txd_to_reg <= 1'b0;
               bus_to_reg <= 1'b0;
               fail_reg <= `BWS_FAIL_NONE;
            end
            else
            begin
               if (ch_txd_to_det[ch])
                  txd_to_reg <= 1'b1;
               else if (txd_sync_reg[ch] || idle)
                  txd_to_reg <= 1'b0;
               if (ch_bus_to_det[ch])
                  bus_to_reg <= 1'b1;
               else if (ch_recessive[ch] || idle)
                  bus_to_reg <= 1'b0;
               // A new fault wins over a clear in the same cycle
               if (code != `BWS_FAIL_NONE)
                  fail_reg <= code;
               else if (field_clr)
                  fail_reg <= `BWS_FAIL_NONE;
            end
         end

         bws_tx_guard
         #(
            .CNT_W(TX_CNT_W)
         )
         u_guard
         (
            .core_clk(core_clk),
            .rst(rst),
            .fault_active(fault_any),
            .txd_high(txd_sync_reg[ch]),
            .tx_enable(ch_tx_enable[ch])
         );

         assign fail_fields[2*ch+1:2*ch] = fail_reg;
      end
   endgenerate

   // Bus status flags and selective wake control
   reg uv_flag_reg;
   reg selective_wake_timeout_flag_reg;
   reg selective_wake_system_error_reg;
   reg selective_wake_timeout_flag_block_reg;
   reg silent_prev_reg;
   reg irq_n_prev_reg;

   wire irq_fall = irq_n_prev_reg && !interrupt_out_n;
   wire selective_wake_timeout_flag_set = selective_wake_enable_bit && can_silent_indication && !silent_prev_reg;
   wire selective_wake_system_error_set = selective_wake_enable_bit &&
      (swk_config_error || (swk_err_count > `BWS_SWK_ERR_LIMIT));
   wire selective_wake_timeout_flag_clr = clr_bus && cmd_clr_mask[`BWS_BUS_SELECTIVE_WAKE_TIMEOUT_FLAG] && !selective_wake_timeout_flag_block_reg;
   wire irq_mode = (dev_mode == `BWS_DEV_NORMAL) || (dev_mode == `BWS_DEV_STOP);

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         uv_flag_reg <= 1'b0;
         selective_wake_timeout_flag_reg <= 1'b0;
         selective_wake_system_error_reg <= 1'b0;
         selective_wake_timeout_flag_block_reg <= 1'b0;
         silent_prev_reg <= 1'b0;
         irq_n_prev_reg <= 1'b1;
         selective_wake_timeout_flag_irq_req <= 1'b0;
         selective_wake_active <= 1'b0;
      end
      else
      begin
         silent_prev_reg <= can_silent_indication;
         irq_n_prev_reg <= interrupt_out_n;
         if (uv_active)
            uv_flag_reg <= 1'b1;
         else if (clr_bus && cmd_clr_mask[`BWS_BUS_UV])
            uv_flag_reg <= 1'b0;
         if (selective_wake_timeout_flag_set)
            selective_wake_timeout_flag_reg <= 1'b1;
         else if (selective_wake_timeout_flag_clr)
            selective_wake_timeout_flag_reg <= 1'b0;
         // Clear stays locked from the set until the interrupt line falls
         if (selective_wake_timeout_flag_set)
            selective_wake_timeout_flag_block_reg <= 1'b1;
         else if (irq_fall)
            selective_wake_timeout_flag_block_reg <= 1'b0;
         selective_wake_timeout_flag_irq_req <= selective_wake_timeout_flag_set && selective_wake_timeout_irq_mask && irq_mode;
         if (selective_wake_system_error_set)
            selective_wake_system_error_reg <= 1'b1;
         else if (clr_bus && cmd_clr_mask[`BWS_BUS_SELECTIVE_WAKE_SYSTEM_ERROR])
            selective_wake_system_error_reg <= 1'b0;
         if (!selective_wake_enable_bit)
            selective_wake_active <= 1'b0;
         else if (!selective_wake_active && !selective_wake_system_error_reg)
            selective_wake_active <= 1'b1;
      end
   end

   // Restart leaves every implemented bus status bit as it was
   wire [15:0] bus_stat = {9'h000, fail_fields[3:2], selective_wake_timeout_flag_reg, selective_wake_system_error_reg,
      fail_fields[1:0], uv_flag_reg} & `BWS_BUS_IMPL_MASK;

   // Wake source flags, one cell per bit
   reg [2:0] mode_prev_reg;
   wire fs_entry = (dev_mode == `BWS_DEV_FAILSAFE) && (mode_prev_reg != `BWS_DEV_FAILSAFE);
   wire [15:0] wake_set;
   wire [15:0] wake_stat;
   assign wake_set = ({15'h0000, lin_bus_wake} << `BWS_WAKE_LIN) |
      ({15'h0000, can_bus_wake} << `BWS_WAKE_CAN) |
      ({15'h0000, timer2_wake} << `BWS_WAKE_TMR2) |
      ({15'h0000, timer1_wake} << `BWS_WAKE_TMR1) |
      ({12'h000, wake_in} << `BWS_WAKE_IN_LO);

   always @(posedge core_clk)
   begin
      if (rst)
         mode_prev_reg <= `BWS_DEV_INIT;
      else
         mode_prev_reg <= dev_mode;
   end

   genvar b;
   generate
      for (b = 0; b < 16; b = b + 1)
      begin : wake_bit
         reg flag_reg;
         localparam [15:0] IMPL = `BWS_WAKE_IMPL_MASK;
         localparam [15:0] KEEP = `BWS_WAKE_RESTART_KEEP;
         always @(posedge core_clk)
         begin
            if (rst || !IMPL[b])
               flag_reg <= 1'b0;
            else if (fs_entry)
               flag_reg <= 1'b0;
            else if (restart && !KEEP[b])
               flag_reg <= 1'b0;
            else if (wake_set[b])
               flag_reg <= 1'b1;
            else if (clr_wake && cmd_clr_mask[b])
               flag_reg <= 1'b0;
         end
         assign wake_stat[b] = flag_reg;
      end
   endgenerate

   // Read returns the value before any clear carried by the same command
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         rd_data <= `BWS_STAT_RESET;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_valid <= cmd_valid;
         if (cmd_valid)
         begin
            if (cmd_addr == `BWS_ADDR_BUS_STAT)
               rd_data <= bus_stat;
            else if (cmd_addr == `BWS_ADDR_WAKE_STAT)
               rd_data <= wake_stat & `BWS_WAKE_IMPL_MASK;
            else
               rd_data <= `BWS_STAT_RESET;
         end
      end
   end
endmodule
`default_nettype wire

// ===== design/bws_tx_guard.v
// Transmitter release guard: blocks transmit during a fault, releases after a recessive hold
`timescale 1ns/1ps
`default_nettype none
`include "bws_regs.vh"
module bws_tx_guard
#(
   parameter CNT_W = 16,
   parameter [CNT_W-1:0] HOLD_CYCLES = `BWS_TX_EN_CYCLES
)
(
   input wire core_clk,
   input wire rst,
   input wire fault_active,
   input wire txd_high,
   output wire tx_enable
);
   localparam [1:0] ST_ENABLED = 2'h0;
   localparam [1:0] ST_BLOCKED = 2'h1;
   localparam [1:0] ST_RELEASE = 2'h2;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg [CNT_W-1:0] cnt_reg;
   reg [CNT_W-1:0] cnt_next;

   assign tx_enable = (state_reg == ST_ENABLED) && !fault_active;

   always @*
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         ST_ENABLED:
         begin
            if (fault_active)
               state_next = ST_BLOCKED;
         end
         ST_BLOCKED:
         begin
            cnt_next = {CNT_W{1'b0}};
            if (!fault_active)
               state_next = ST_RELEASE;
         end
         ST_RELEASE:
         begin
            // Any low on the transmit input restarts the hold time
            if (fault_active)
               state_next = ST_BLOCKED;
            else if (!txd_high)
               cnt_next = {CNT_W{1'b0}};
            else if (cnt_reg + 1'b1 >= HOLD_CYCLES)
               state_next = ST_ENABLED;
            else
               cnt_next = cnt_reg + 1'b1;
         end
         default:
         begin
            state_next = ST_BLOCKED;
         end
      endcase
   end

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         state_reg <= ST_ENABLED;
         cnt_reg <= {CNT_W{1'b0}};
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end
endmodule
`default_nettype wire

// ===== inc/bws_regs.vh
// Offsets, field positions, reset values, mode codes and timing for the bus and wake status block
`ifndef BWS_REGS_VH
`define BWS_REGS_VH

`define BWS_ADDR_BUS_STAT 7'h43
`define BWS_ADDR_WAKE_STAT 7'h44

`define BWS_STAT_RESET 16'h0000
`define BWS_BUS_RESTART_KEEP 16'h007f
`define BWS_WAKE_RESTART_KEEP 16'h0782
`define BWS_BUS_IMPL_MASK 16'h007f
`define BWS_WAKE_IMPL_MASK 16'h078f

`define BWS_BUS_LIN_LO 5
`define BWS_BUS_SELECTIVE_WAKE_TIMEOUT_FLAG 4
`define BWS_BUS_SELECTIVE_WAKE_SYSTEM_ERROR 3
`define BWS_BUS_CAN_LO 1
`define BWS_BUS_UV 0

`define BWS_WAKE_LIN 10
`define BWS_WAKE_CAN 9
`define BWS_WAKE_TMR2 8
`define BWS_WAKE_TMR1 7
`define BWS_WAKE_IN_LO 0

`define BWS_FAIL_NONE 2'h0
`define BWS_FAIL_TSD 2'h1
`define BWS_FAIL_TXD_TO 2'h2
`define BWS_FAIL_BUS_TO 2'h3

`define BWS_XCVR_OFF 2'h0
`define BWS_XCVR_WAKE 2'h1
`define BWS_XCVR_RXONLY 2'h2
`define BWS_XCVR_NORMAL 2'h3

`define BWS_DEV_INIT 3'h0
`define BWS_DEV_NORMAL 3'h1
`define BWS_DEV_STOP 3'h2
`define BWS_DEV_SLEEP 3'h3
`define BWS_DEV_RESTART 3'h4
`define BWS_DEV_FAILSAFE 3'h5

`define BWS_SWK_ERR_LIMIT 6'h20

`define BWS_CLK_PERIOD_NS 50
`define BWS_TX_EN_TIME_NS 10000
`define BWS_TX_EN_CYCLES ((`BWS_TX_EN_TIME_NS + `BWS_CLK_PERIOD_NS - 1) / `BWS_CLK_PERIOD_NS)

`endif

// ===== tb/bws_int_pin.sv
// Interrupt pin model: pulls the active-low pin low some cycles after each request
`timescale 1ns/1ps
`default_nettype none
module bws_int_pin
#(
   parameter DLY = 20
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic irq_req,
   output logic pin_n
);
   int cnt;
   always @(posedge core_clk)
   begin
      if (rst)
         cnt <= 0;
      else if (irq_req)
         cnt <= DLY + 4;
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
   // Late pulse so the clear-blocking window is wide
   assign pin_n = !(cnt > 0 && cnt <= 4);
endmodule
`default_nettype wire

// ===== tb/bws_status_regs_asserts.sv
// Checker for the bus and wake status block
`timescale 1ns/1ps
`default_nettype none
module bws_status_regs_asserts
(
   input wire core_clk,
   input wire rst,
   input wire [2:0] dev_mode,
   input wire [6:0] cmd_addr,
   input wire [15:0] rd_data,
   input wire rd_valid,
   input wire [1:0] can_mode,
   input wire can_txd,
   input wire can_bus_to_det,
   input wire can_supply_below,
   input wire can_tx_enable,
   input wire [1:0] lin_mode,
   input wire lin_txd_to_det,
   input wire lin_tx_enable,
   input wire selective_wake_enable_bit,
   input wire can_silent_indication,
   input wire selective_wake_timeout_irq_mask,
   input wire selective_wake_timeout_flag_irq_req
);
   reg [8:0] hi_cnt;
   // Cycles the raw transmit input has been high
   always @(posedge core_clk)
   begin
      if (rst || !can_txd)
         hi_cnt <= 9'h000;
      else if (hi_cnt != 9'h1ff)
         hi_cnt <= hi_cnt + 9'h001;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_bus_reserved: assert property (
      rd_valid && $past(cmd_addr) == 7'h43 |-> rd_data[15:7] == 9'h000)
      else $error("bus status reserved bits set");
   a_wake_reserved: assert property (
      rd_valid && $past(cmd_addr) == 7'h44 |-> (rd_data & 16'hf870) == 16'h0000)
      else $error("wake status reserved bits set");
   a_uv_tx_off: assert property (
      can_supply_below && can_mode == 2'h3 ##1 can_supply_below && can_mode == 2'h3
      |-> !can_tx_enable)
      else $error("transmitter on during undervoltage");
   a_bus_to_off: assert property (
      can_bus_to_det && can_mode == 2'h3 |=> !can_tx_enable)
      else $error("transmitter on after bus timeout");
   a_lin_txd_off: assert property (
      lin_txd_to_det && lin_mode == 2'h3 |=> !lin_tx_enable)
      else $error("transmitter on after transmit timeout");
   a_tx_hold_time: assert property (
      $rose(can_tx_enable) |-> hi_cnt >= 9'h0c6)
      else $error("transmitter enabled before hold time");
   a_timeout_irq: assert property (
      $rose(can_silent_indication) && selective_wake_enable_bit
      && selective_wake_timeout_irq_mask && (dev_mode == 3'h1 || dev_mode == 3'h2)
      |=> selective_wake_timeout_flag_irq_req)
      else $error("no timeout interrupt request");
   a_irq_masked: assert property (
      selective_wake_timeout_flag_irq_req |-> $past(selective_wake_timeout_irq_mask))
      else $error("interrupt request while masked");
   c_irq: cover property (selective_wake_timeout_flag_irq_req);
   c_tx_back: cover property ($rose(can_tx_enable));
   c_read_set: cover property (rd_valid && rd_data != 16'h0000);
endmodule
`default_nettype wire

// ===== tb/bws_status_regs_test.sv
// Self-checking bench for the bus and wake status block
`timescale 1ns/1ps
`default_nettype none
module bws_status_regs_test;
   typedef struct packed {logic [15:0] ev; logic [6:0] a; logic [15:0] exp;} bws_row_t;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic restart = 1'b0;
   logic [2:0] dev_mode = 3'h1;
   logic cmd_valid = 1'b0;
   logic [6:0] cmd_addr = 7'h00;
   logic cmd_clear = 1'b0;
   logic [15:0] ev = 16'h0000;
   logic [15:0] clr_mask = 16'hffff;
   logic [1:0] can_mode = 2'h3;
   logic can_txd = 1'b1;
   logic bus_rec = 1'b1;
   logic swk_en = 1'b0;
   logic silent = 1'b0;
   logic cfg_err = 1'b0;
   logic [5:0] err_cnt = 6'h00;
   logic irq_mask = 1'b1;
   wire [15:0] rd_data;
   wire rd_valid, can_tx_enable, lin_tx_enable, swk_active, irq_req, int_n;
   int n_fail = 0;
   int checks = 0;
   int cyc = 0;
   // Stimulus bits: 14 uv, 13:11 lin faults, 10:7 wake, 6:4 can faults, 3:0 wake inputs
   bws_row_t rows [0:15] = '{'{16'h0400, 7'h44, 16'h0400}, '{16'h0200, 7'h44, 16'h0200},
      '{16'h0100, 7'h44, 16'h0100}, '{16'h0080, 7'h44, 16'h0080},
      '{16'h0008, 7'h44, 16'h0008}, '{16'h0004, 7'h44, 16'h0004},
      '{16'h0002, 7'h44, 16'h0002}, '{16'h0001, 7'h44, 16'h0001},
      '{16'h0010, 7'h43, 16'h0002}, '{16'h0020, 7'h43, 16'h0004},
      '{16'h0040, 7'h43, 16'h0006}, '{16'h0800, 7'h43, 16'h0020},
      '{16'h1000, 7'h43, 16'h0040}, '{16'h2000, 7'h43, 16'h0060},
      '{16'h4000, 7'h43, 16'h0001}, '{16'h0000, 7'h45, 16'h0000}};
   bws_status_regs u_bws_status_regs (.core_clk, .rst, .restart, .dev_mode, .cmd_valid,
      .cmd_addr, .cmd_clear, .cmd_clr_mask(clr_mask), .rd_data, .rd_valid, .can_mode,
      .can_tsd(ev[4]), .can_txd, .can_txd_to_det(ev[5]), .can_bus_recessive(bus_rec),
      .can_bus_to_det(ev[6]), .can_supply_below(ev[14]), .can_tx_enable, .lin_mode(2'h3),
      .lin_tsd(ev[11]), .lin_txd(1'b1), .lin_txd_to_det(ev[12]), .lin_bus_recessive(1'b1),
      .lin_bus_to_det(ev[13]), .lin_tx_enable, .selective_wake_enable_bit(swk_en),
      .can_silent_indication(silent), .swk_config_error(cfg_err), .swk_err_count(err_cnt),
      .selective_wake_active(swk_active), .selective_wake_timeout_irq_mask(irq_mask),
      .interrupt_out_n(int_n), .selective_wake_timeout_flag_irq_req(irq_req), .lin_bus_wake(ev[10]),
      .can_bus_wake(ev[9]), .timer1_wake(ev[7]), .timer2_wake(ev[8]), .wake_in(ev[3:0]));
   bws_int_pin u_bws_int_pin (.core_clk, .rst, .irq_req, .pin_n(int_n));
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask
   // One command; the extra cycle keeps consecutive reads apart
   task automatic rd(input logic [6:0] a, input logic c, input logic [15:0] exp);
      cmd_valid = 1'b1;
      cmd_addr = a;
      cmd_clear = c;
      tick(1);
      cmd_valid = 1'b0;
      cmd_clear = 1'b0;
      chk("rd_data", rd_data, exp);
      chk("rd_valid", {15'h0000, rd_valid}, 16'h0001);
      tick(1);
      chk("rd_valid", {15'h0000, rd_valid}, 16'h0000);
   endtask
   task automatic test_done();
      $display("checks %0d failures %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_fail++;
         test_done();
      end
   end
   initial
   begin
      tick(8);
      rst = 1'b0;
      rd(7'h43, 1'b0, 16'h0000);
      rd(7'h44, 1'b0, 16'h0000);
      foreach (rows[i])
      begin
         ev = rows[i].ev;
         tick(3);
         ev = 16'h0000;
         tick(3);
         rd(rows[i].a, 1'b1, rows[i].exp);
         rd(rows[i].a, 1'b0, 16'h0000);
      end
      chk("lin_tx_enable", {15'h0000, lin_tx_enable}, 16'h0000);
      $display("rows done");
      ev = 16'h079f;
      tick(2);
      ev = 16'h0000;
      restart = 1'b1;
      tick(1);
      restart = 1'b0;
      tick(2);
      rd(7'h44, 1'b1, 16'h0782);
      rd(7'h43, 1'b1, 16'h0002);
      ev = 16'h078f;
      tick(2);
      ev = 16'h0000;
      dev_mode = 3'h5;
      tick(2);
      dev_mode = 3'h1;
      rd(7'h44, 1'b0, 16'h0000);
      can_mode = 2'h0;
      ev = 16'h4000;
      tick(3);
      ev = 16'h0000;
      can_mode = 2'h3;
      rd(7'h43, 1'b1, 16'h0000);
      can_mode = 2'h2;
      ev = 16'h4000;
      tick(3);
      ev = 16'h0000;
      can_mode = 2'h3;
      rd(7'h43, 1'b1, 16'h0001);
      // Bus held dominant keeps the timeout alive until wake-capable mode
      bus_rec = 1'b0;
      ev = 16'h0040;
      tick(1);
      ev = 16'h0000;
      tick(3);
      rd(7'h43, 1'b1, 16'h0006);
      rd(7'h43, 1'b0, 16'h0006);
      can_mode = 2'h1;
      tick(2);
      rd(7'h43, 1'b1, 16'h0006);
      rd(7'h43, 1'b0, 16'h0000);
      can_mode = 2'h3;
      bus_rec = 1'b1;
      $display("restart and modes done");
      can_txd = 1'b0;
      ev = 16'h0040;
      tick(1);
      ev = 16'h0000;
      tick(20);
      chk("can_tx_enable", {15'h0000, can_tx_enable}, 16'h0000);
      can_txd = 1'b1;
      tick(190);
      chk("can_tx_enable", {15'h0000, can_tx_enable}, 16'h0000);
      tick(20);
      chk("can_tx_enable", {15'h0000, can_tx_enable}, 16'h0001);
      chk("lin_tx_enable", {15'h0000, lin_tx_enable}, 16'h0001);
      rd(7'h43, 1'b1, 16'h0006);
      $display("transmit hold done");
      irq_mask = 1'b0;
      silent = 1'b1;
      tick(2);
      silent = 1'b0;
      irq_mask = 1'b1;
      swk_en = 1'b1;
      rd(7'h43, 1'b0, 16'h0000);
      silent = 1'b1;
      tick(1);
      chk("irq_req", {15'h0000, irq_req}, 16'h0001);
      tick(1);
      silent = 1'b0;
      rd(7'h43, 1'b1, 16'h0010);
      rd(7'h43, 1'b1, 16'h0010);
      tick(30);
      rd(7'h43, 1'b1, 16'h0010);
      rd(7'h43, 1'b0, 16'h0000);
      $display("timeout flag done");
      err_cnt = 6'h20;
      tick(3);
      rd(7'h43, 1'b0, 16'h0000);
      err_cnt = 6'h21;
      tick(3);
      err_cnt = 6'h00;
      rd(7'h43, 1'b0, 16'h0008);
      swk_en = 1'b0;
      tick(3);
      swk_en = 1'b1;
      tick(3);
      chk("swk_active", {15'h0000, swk_active}, 16'h0000);
      rd(7'h43, 1'b1, 16'h0008);
      cfg_err = 1'b1;
      tick(3);
      cfg_err = 1'b0;
      rd(7'h43, 1'b1, 16'h0008);
      $display("system error done");
      // One mask bit clears a whole fault field; other flags stay
      ev = 16'h2402;
      tick(3);
      ev = 16'h0000;
      tick(2);
      clr_mask = 16'h0020;
      rd(7'h43, 1'b1, 16'h0060);
      rd(7'h43, 1'b0, 16'h0000);
      clr_mask = 16'h0400;
      rd(7'h44, 1'b1, 16'h0402);
      clr_mask = 16'hffff;
      rd(7'h44, 1'b1, 16'h0002);
      $display("partial clear done");
      test_done();
   end
endmodule
bind bws_status_regs bws_status_regs_asserts u_bws_status_regs_asserts (.core_clk, .rst,
   .dev_mode, .cmd_addr, .rd_data, .rd_valid, .can_mode, .can_txd, .can_bus_to_det,
   .can_supply_below, .can_tx_enable, .lin_mode, .lin_txd_to_det, .lin_tx_enable,
   .selective_wake_enable_bit, .can_silent_indication, .selective_wake_timeout_irq_mask,
   .selective_wake_timeout_flag_irq_req);
`default_nettype wire
